// File: logic/cfgio_consts.vh
/*
  Constants for the configurable I/O port block: pin layout, register
  map, availability masks per mode and reset values.
  Assumes the includer works on a 56-bit pin vector, port A in the
  lowest byte, ports A to G at byte lanes 0 to 6.
*/
`ifndef CFGIO_CONSTS_VH
`define CFGIO_CONSTS_VH

// ----------------------------------------------------------------
// Pin layout
// ----------------------------------------------------------------
`define CFGIO_NPORT      7
`define CFGIO_PORT_W     8
`define CFGIO_PIN_W      56
`define CFGIO_ADDR_W     16
`define CFGIO_DPORT_W    16
`define CFGIO_PORT_D     3
`define CFGIO_PORT_E     4
`define CFGIO_PORT_F     5
`define CFGIO_PORT_G     6

// ----------------------------------------------------------------
// Register map, word index = {kind, port}
// ----------------------------------------------------------------
`define CFGIO_AV_ADDR_W  6
`define CFGIO_KIND_PIN   3'h0
`define CFGIO_KIND_DOUT  3'h1
`define CFGIO_KIND_DIR   3'h2
`define CFGIO_KIND_CTL   3'h3
`define CFGIO_KIND_LOUT  3'h4
`define CFGIO_REG_RESET  8'h00

// ----------------------------------------------------------------
// Availability masks per mode
// ----------------------------------------------------------------
`define CFGIO_IMPL_MASK  56'hFFFFFF0FFFFFFF
`define CFGIO_LOUT_AVAIL 56'h00000000FFFFFF
`define CFGIO_LIN_AVAIL  56'h00FF000FFFFFFF
`define CFGIO_ADDR_AVAIL 56'hFFFFFF00000000
`define CFGIO_DP_AVAIL   56'hFFFF0000000000
`define CFGIO_BURST_LOW  56'h000F0F00000000

`endif

// File: logic/cfgio_port_mux.v
/*
  Output multiplexer for one 8-bit port: picks the pin source and the
  pin enable from the fixed configuration and the host registers.
  Assumes all inputs come from logic on sys_clk.
*/
`timescale 1ns/1ns
module cfgio_port_mux (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire [7:0] dout,
  input  wire [7:0] dir,
  input  wire [7:0] ctl,
  input  wire [7:0] lout,
  input  wire [7:0] loe,
  input  wire [7:0] addr,
  input  wire [7:0] addr_ok,
  input  wire [7:0] cfg_lout,
  input  wire [7:0] cfg_lin,
  input  wire [7:0] cfg_dp,
  input  wire [7:0] dp_data,
  input  wire       dp_oe,
  input  wire [7:0] pattern,
  input  wire       pat_act,
  output reg  [7:0] pin_out_q,
  output reg  [7:0] pin_oe_q
);

  reg [7:0] pin_out_d;
  reg [7:0] pin_oe_d;
  integer   i;

  // ----------------------------------------------------------------
  // Per-pin source select
  // ----------------------------------------------------------------
  always @* begin
    pin_out_d = 8'h00;
    pin_oe_d  = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (cfg_dp[i]) begin
        if (pat_act) begin
          pin_out_d[i] = pattern[i];
          pin_oe_d[i]  = 1'b1;
        end else begin
          pin_out_d[i] = dp_data[i];
          pin_oe_d[i]  = dp_oe;
        end
      end else if (cfg_lout[i]) begin
        pin_out_d[i] = lout[i];
        pin_oe_d[i]  = loe[i];
      end else if (addr_ok[i] &&
                   (loe[i] || (dir[i] && ctl[i]))) begin
        pin_out_d[i] = addr[i];
        pin_oe_d[i]  = 1'b1;
      end else if (!cfg_lin[i]) begin
        pin_out_d[i] = dout[i];
        pin_oe_d[i]  = dir[i];
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_out_q <= 8'h00;
      pin_oe_q  <= 8'h00;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
    end
  end

endmodule

// File: logic/cfgio_ports.v
/*
  Seven configurable I/O ports (six of eight pins, one of four) with
  host registers over Avalon-MM, output multiplexing and readback.
  Assumes pin inputs are asynchronous; logic array, latched address,
  data-port and host reset-state inputs are on sys_clk.
*/
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
// Summary of operation
// - Seven ports: six with eight pins, port D with four pins.
// - Per-pin mux picks output register, latched address or logic output.
// - Readback places one selected source at a time on read data.
// - Data-out and direction reads return current host-written contents; control reads do so on E, F, G only.
// - Logic, data-port, burst-host and reset-pattern modes are fixed.
// - A pin serves only one function, by fixed priority.
// - Each mode is allowed only on its documented ports.
// - On E, F, G control 0 is host I/O, 1 with direction is address.
// - Direction bit 1 makes an output, 0 an input, writable anytime.
// - Output pins drive the data-out register; inputs read live pins.
// - Ports A, B, C have no control register, host I/O by default.
// - Logic mode pins feed the logic cells or take logic outputs.
// - Address out when logic enable term or direction and control set.
// - Address nibbles map onto E, F low/high and G low/high nibbles.
// - Burst host: E and F low nibbles carry no address.
// - All configuration registers reset to zero, pins start as inputs.
// - Port D direction has only four active bits.
// - Reset pattern drives data-port pins of F and G during reset with no bus cycle.
`timescale 1ns/1ns
`include "cfgio_consts.vh"
module cfgio_ports #(
  parameter [55:0] CFG_LOGIC_OUT = 56'h00000000000000,
  parameter [55:0] CFG_LOGIC_IN  = 56'h00000000000000,
  parameter [55:0] CFG_DATA_PORT = 56'h00000000000000,
  parameter        CFG_RST_PAT   = 1'b0,
  parameter [15:0] RST_PATTERN   = 16'h0000,
  parameter        CFG_BURST     = 1'b0
) (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [55:0] pin_in,
  output wire [55:0] pin_out,
  output wire [55:0] pin_oe,
  input  wire [55:0] logic_out,
  input  wire [55:0] logic_oe,
  output reg  [55:0] logic_in_q,
  input  wire [15:0] latched_addr,
  input  wire [15:0] dport_data,
  input  wire        dport_oe,
  input  wire        host_rst_act,
  input  wire        bus_cycle_act
);

  // ----------------------------------------------------------------
  // Fixed configuration
  // ----------------------------------------------------------------
  // fixed modes
  wire [55:0] cfg_lout;
  wire [55:0] cfg_lin;
  wire [55:0] cfg_dp;
  wire [55:0] addr_ok;

  assign cfg_lout = CFG_LOGIC_OUT & `CFGIO_LOUT_AVAIL & `CFGIO_IMPL_MASK;
  assign cfg_lin  = CFG_LOGIC_IN & `CFGIO_LIN_AVAIL & `CFGIO_IMPL_MASK;
  assign cfg_dp   = CFG_DATA_PORT & `CFGIO_DP_AVAIL;

  // ----------------------------------------------------------------
  // Address-out availability
  // ----------------------------------------------------------------
  // burst host
  assign addr_ok = CFG_BURST ?
                   (`CFGIO_ADDR_AVAIL & ~`CFGIO_BURST_LOW) :
                   `CFGIO_ADDR_AVAIL;

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  reg  [55:0] dout_q;
  reg  [55:0] dir_q;
  reg  [55:0] ctl_q;
  reg  [55:0] pin_s1_q;
  reg  [55:0] pin_s2_q;
  reg  [31:0] readdata_d;
  wire [2:0]  kind;
  wire [2:0]  port;
  wire [4:0]  ksel;
  wire        take_wr;
  wire [55:0] wr_mask;
  wire [55:0] wr_bits;

  assign kind = avs_address[5:3];
  assign port = avs_address[2:0];
  assign ksel = (port < `CFGIO_NPORT) ? kind_sel(kind) : 5'h00;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Byte of a port within the 56-bit vector
  function [7:0] port_byte;
    input [55:0] vec;
    input [2:0]  idx;
    begin
      case (idx)
        3'h0:    port_byte = vec[7:0];
        3'h1:    port_byte = vec[15:8];
        3'h2:    port_byte = vec[23:16];
        3'h3:    port_byte = vec[31:24];
        3'h4:    port_byte = vec[39:32];
        3'h5:    port_byte = vec[47:40];
        3'h6:    port_byte = vec[55:48];
        default: port_byte = 8'h00;
      endcase
    end
  endfunction

  // One-hot lane mask for a port
  function [55:0] port_mask;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    port_mask = 56'h000000000000FF;
        3'h1:    port_mask = 56'h0000000000FF00;
        3'h2:    port_mask = 56'h00000000FF0000;
        3'h3:    port_mask = 56'h000000FF000000;
        3'h4:    port_mask = 56'h0000FF00000000;
        3'h5:    port_mask = 56'h00FF0000000000;
        3'h6:    port_mask = 56'hFF000000000000;
        default: port_mask = 56'h00000000000000;
      endcase
    end
  endfunction

  // One-hot register kind, shared by write and readback
  function [4:0] kind_sel;
    input [2:0] k;
    begin
      case (k)
        `CFGIO_KIND_PIN:  kind_sel = 5'h01;
        `CFGIO_KIND_DOUT: kind_sel = 5'h02;
        `CFGIO_KIND_DIR:  kind_sel = 5'h04;
        `CFGIO_KIND_CTL:  kind_sel = 5'h08;
        `CFGIO_KIND_LOUT: kind_sel = 5'h10;
        default:          kind_sel = 5'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  // write at ack edge
  assign take_wr = avs_write && !avs_waitrequest &&
                   avs_byteenable[0];

  assign wr_mask = port_mask(port) & `CFGIO_IMPL_MASK;
  assign wr_bits = {7{avs_writedata[7:0]}};

  // ----------------------------------------------------------------
  // Avalon handshake, one wait cycle then one acknowledge cycle
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= readdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  // reset zero
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      dout_q <= {7{`CFGIO_REG_RESET}};
    end else if (take_wr && ksel[1]) begin
      dout_q <= (dout_q & ~wr_mask) | (wr_bits & wr_mask);
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      dir_q <= {7{`CFGIO_REG_RESET}};
    end else if (take_wr && ksel[2]) begin
      dir_q <= (dir_q & ~wr_mask) | (wr_bits & wr_mask);
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ctl_q <= {7{`CFGIO_REG_RESET}};
    end else if (take_wr && ksel[3]) begin
      ctl_q <= (ctl_q & ~(wr_mask & `CFGIO_ADDR_AVAIL)) |
               (wr_bits & wr_mask & `CFGIO_ADDR_AVAIL);
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_s1_q <= 56'h00000000000000;
      pin_s2_q <= 56'h00000000000000;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Readback buffer
  // ----------------------------------------------------------------
  // one source
  always @* begin
    readdata_d = 32'h00000000;
    if (ksel[0]) begin
      readdata_d[7:0] = port_byte(pin_s2_q & `CFGIO_IMPL_MASK, port);
    end
    if (ksel[1]) begin
      readdata_d[7:0] = port_byte(dout_q, port);
    end
    if (ksel[2]) begin
      readdata_d[7:0] = port_byte(dir_q, port);
    end
    if (ksel[3]) begin
      readdata_d[7:0] = port_byte(ctl_q, port);
    end
    if (ksel[4]) begin
      readdata_d[7:0] = port_byte(logic_out & cfg_lout, port);
    end
  end

  // ----------------------------------------------------------------
  // Logic array inputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      logic_in_q <= 56'h00000000000000;
    end else begin
      logic_in_q <= pin_s2_q & cfg_lin;
    end
  end

  // ----------------------------------------------------------------
  // Address, data-port and pattern routing
  // ----------------------------------------------------------------
  wire [55:0] impl_mask;
  wire [55:0] addr_vec;
  wire [55:0] dp_vec;
  wire [55:0] pat_vec;
  wire [55:0] dir_eff;
  wire        pat_act;

  assign impl_mask = `CFGIO_IMPL_MASK;

  assign addr_vec[31:0]  = 32'h00000000;
  assign addr_vec[35:32] = latched_addr[3:0];
  assign addr_vec[39:36] = latched_addr[7:4];
  assign addr_vec[43:40] = latched_addr[3:0];
  assign addr_vec[47:44] = latched_addr[7:4];
  assign addr_vec[51:48] = latched_addr[11:8];
  assign addr_vec[55:52] = latched_addr[15:12];

  // ----------------------------------------------------------------
  // Data port and reset pattern
  // ----------------------------------------------------------------
  assign dp_vec[39:0]   = 40'h0000000000;
  assign dp_vec[47:40]  = dport_data[7:0];
  assign dp_vec[55:48]  = dport_data[15:8];
  assign pat_vec[39:0]  = 40'h0000000000;
  assign pat_vec[47:40] = RST_PATTERN[7:0];
  assign pat_vec[55:48] = RST_PATTERN[15:8];

  assign pat_act = CFG_RST_PAT && host_rst_act && !bus_cycle_act;

  // ----------------------------------------------------------------
  // Host I/O direction guard
  // ----------------------------------------------------------------
  // logic input guard
  assign dir_eff = dir_q & ~cfg_lin;

  // ----------------------------------------------------------------
  // Per-port output multiplexers
  // ----------------------------------------------------------------
  // seven ports
  genvar g;
  generate
    for (g = 0; g < `CFGIO_NPORT; g = g + 1) begin : gen_port
      wire [7:0] p_out;
      wire [7:0] p_oe;
      cfgio_port_mux u_mux (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .dout      (dout_q[g*8 +: 8]),
        .dir       (dir_eff[g*8 +: 8]),
        .ctl       (ctl_q[g*8 +: 8]),
        .lout      (logic_out[g*8 +: 8]),
        .loe       (logic_oe[g*8 +: 8]),
        .addr      (addr_vec[g*8 +: 8]),
        .addr_ok   (addr_ok[g*8 +: 8]),
        .cfg_lout  (cfg_lout[g*8 +: 8]),
        .cfg_lin   (cfg_lin[g*8 +: 8]),
        .cfg_dp    (cfg_dp[g*8 +: 8]),
        .dp_data   (dp_vec[g*8 +: 8]),
        .dp_oe     (dport_oe),
        .pattern   (pat_vec[g*8 +: 8]),
        .pat_act   (pat_act),
        .pin_out_q (p_out),
        .pin_oe_q  (p_oe)
      );
      assign pin_out[g*8 +: 8] = p_out & impl_mask[g*8 +: 8];
      assign pin_oe[g*8 +: 8]  = p_oe;
    end
  endgenerate

endmodule

// File: tb/cfgio_ports_checker.sv
/*
  Checker for cfgio_ports: bus handshake, pin enables and logic inputs.
  Assumes it is bound to cfgio_ports with the same pin-mask parameters.
*/
`timescale 1ns/1ns
`include "cfgio_consts.vh"
module cfgio_ports_checker #(
  parameter [55:0] CFG_LOGIC_OUT = 56'h0,
  parameter [55:0] CFG_LOGIC_IN  = 56'h0
) (
  input wire        sys_clk,
  input wire        reset_n,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [55:0] pin_out,
  input wire [55:0] pin_oe,
  input wire [55:0] logic_oe,
  input wire [55:0] logic_in_q
);
  localparam [55:0] LO_M = CFG_LOGIC_OUT & `CFGIO_LOUT_AVAIL;
  localparam [55:0] LI_M = CFG_LOGIC_IN & `CFGIO_LIN_AVAIL;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wait_answer: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_single: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rd_upper_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_d_upper_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pin_oe[31:28] == 4'h0 && pin_out[31:28] == 4'h0)
    else $error("missing pins of port D active");
  a_reset_clear: assert property (@(posedge sys_clk)
    !reset_n |=> pin_oe == 56'h0 && avs_waitrequest)
    else $error("reset did not clear pins and bus");
  a_lin_masked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (logic_in_q & ~LI_M) == 56'h0)
    else $error("logic input on unconfigured pin");
  a_lout_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(reset_n) |-> (pin_oe & LO_M) == ($past(logic_oe) & LO_M))
    else $error("logic output enable not followed");
  a_dir_write_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $changed(pin_oe[7:0]) |-> $past(avs_write && !avs_waitrequest, 2))
    else $error("port A enable changed without a write");
endmodule
bind cfgio_ports cfgio_ports_checker #(
  .CFG_LOGIC_OUT(CFG_LOGIC_OUT),
  .CFG_LOGIC_IN (CFG_LOGIC_IN)
) cfgio_ports_checker_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pin_out(pin_out), .pin_oe(pin_oe),
  .logic_oe(logic_oe), .logic_in_q(logic_in_q)
);

// File: tb/cfgio_pin_far.sv
/*
  Far-side pin model: external devices and pull-ups on the port pins.
  Assumes pins have pull-ups; external drive only where ext_en is set.
*/
`timescale 1ns/1ns
module cfgio_pin_far (
  input  wire [55:0] pin_out,
  input  wire [55:0] pin_oe,
  input  wire [55:0] ext_val,
  input  wire [55:0] ext_en,
  output wire [55:0] pin_in
);
  // Device drive wins, then external drive, else pull-up level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en);
endmodule

// File: tb/configurable_io_ports_bench.sv
/*
  Self-checking bench for cfgio_ports over Avalon-MM register calls.
  Assumes cfgio_pin_far models the pins and the checker is bound.
*/
`timescale 1ns/1ns
module configurable_io_ports_bench;
  reg         sys_clk, reset_n, avs_read, avs_write, dport_oe;
  reg         host_rst_act, bus_cycle_act;
  reg  [5:0]  avs_address;
  reg  [31:0] avs_writedata;
  reg  [3:0]  avs_byteenable;
  reg  [55:0] logic_out, logic_oe, ext_val, ext_en;
  reg  [15:0] latched_addr, dport_data;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [55:0] pin_in, pin_out, pin_oe, logic_in_q;
  reg  [7:0]  rd;
  integer     n_errors, compares, cyc, p;

  cfgio_ports #(.CFG_LOGIC_OUT(56'h00000000FF0000),
    .CFG_LOGIC_IN(56'h00000000000F00), .CFG_DATA_PORT(56'h00FF0000000000),
    .CFG_RST_PAT(1'b1), .RST_PATTERN(16'h3C96))
  cfgio_ports_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .logic_out(logic_out), .logic_oe(logic_oe), .logic_in_q(logic_in_q),
    .latched_addr(latched_addr), .dport_data(dport_data),
    .dport_oe(dport_oe), .host_rst_act(host_rst_act),
    .bus_cycle_act(bus_cycle_act));
  cfgio_pin_far cfgio_pin_far_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [55:0] got, input [55:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [5:0] ad, input [7:0] wd);
    begin
      @(posedge sys_clk);
      avs_address <= ad;
      avs_writedata <= {24'h000000, wd};
      avs_write <= w;
      avs_read <= !w;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task rdchk(input [5:0] ad, input [7:0] exp);
    begin
      bus(1'b0, ad, 8'h00);
      chk({48'h0, rd}, {48'h0, exp});
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial cyc = 0;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {reset_n, avs_read, avs_write, dport_oe, host_rst_act} = 5'h00;
    {bus_cycle_act, avs_address, avs_writedata} = 39'h0;
    avs_byteenable = 4'hF;
    {logic_out, logic_oe, ext_val, ext_en} = 224'h0;
    {latched_addr, dport_data} = 32'h0;
    n_errors = 0;
    compares = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (p = 0; p < 7; p = p + 1) rdchk(6'h10 + p[5:0], 8'h00);
    chk(pin_oe, 56'h0);
    $display("test reset done");
    ext_val[7:0] <= 8'hC3;
    ext_en[7:0] <= 8'hFF;
    bus(1'b1, 6'h08, 8'hA5);
    bus(1'b1, 6'h10, 8'hFF);
    repeat (3) @(posedge sys_clk);
    chk(pin_out[7:0], 8'hA5);
    chk(pin_oe[7:0], 8'hFF);
    rdchk(6'h08, 8'hA5);
    bus(1'b1, 6'h10, 8'h0F);
    repeat (3) @(posedge sys_clk);
    chk(pin_oe[7:0], 8'h0F);
    rdchk(6'h00, 8'hC5);
    $display("test host io done");
    bus(1'b1, 6'h13, 8'hFF);
    rdchk(6'h13, 8'h0F);
    chk(pin_oe[31:24], 8'h0F);
    bus(1'b1, 6'h18, 8'hFF);
    rdchk(6'h18, 8'h00);
    rdchk(6'h28, 8'h00);
    avs_byteenable <= 4'hE;
    bus(1'b1, 6'h08, 8'h5A);
    avs_byteenable <= 4'hF;
    rdchk(6'h08, 8'hA5);
    $display("test refused done");
    latched_addr <= 16'hC35A;
    bus(1'b1, 6'h0C, 8'h11);
    bus(1'b1, 6'h14, 8'hFF);
    repeat (3) @(posedge sys_clk);
    chk(pin_out[39:32], 8'h11);
    bus(1'b1, 6'h1C, 8'hFF);
    bus(1'b1, 6'h1E, 8'hF0);
    bus(1'b1, 6'h16, 8'hFF);
    repeat (3) @(posedge sys_clk);
    chk(pin_out[39:32], 8'h5A);
    chk(pin_out[55:48], 8'hC0);
    rdchk(6'h1C, 8'hFF);
    $display("test address done");
    ext_val[15:8] <= 8'h6B;
    ext_en[15:8] <= 8'hFF;
    logic_out[23:16] <= 8'h3C;
    logic_oe[23:16] <= 8'h0F;
    bus(1'b1, 6'h11, 8'hF0);
    repeat (4) @(posedge sys_clk);
    chk(logic_in_q[15:8], 8'h0B);
    chk(pin_oe[15:8], 8'hF0);
    chk(pin_oe[23:16], 8'h0F);
    chk(pin_out[19:16], 4'hC);
    rdchk(6'h22, 8'h3C);
    $display("test logic done");
    host_rst_act <= 1'b1;
    bus_cycle_act <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(pin_oe[47:40], 8'h00);
    bus_cycle_act <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(pin_out[47:40], 8'h96);
    chk(pin_oe[47:40], 8'hFF);
    host_rst_act <= 1'b0;
    dport_oe <= 1'b1;
    dport_data <= 16'hA55A;
    repeat (4) @(posedge sys_clk);
    chk(pin_out[47:40], 8'h5A);
    $display("test data port done");
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdchk(6'h10, 8'h00);
    rdchk(6'h1C, 8'h00);
    $display("test mid reset done");
    tally_and_finish;
  end
endmodule
